// ---- pkg/sfrps_cfg.svh ----
// Constants for the serial flash command sequencer.
// Assumes inclusion by bare name from pkg/ on the include path.
`ifndef SFRPS_CFG_SVH
`define SFRPS_CFG_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFRPS_OP_WRSR 8'h01
`define SFRPS_OP_PP 8'h02
`define SFRPS_OP_READ 8'h03
`define SFRPS_OP_WRDI 8'h04
`define SFRPS_OP_RDSR 8'h05
`define SFRPS_OP_WREN 8'h06
`define SFRPS_OP_FAST 8'h0b
`define SFRPS_OP_DUAL 8'h3b

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define SFRPS_ST_BUSY 0
`define SFRPS_ST_WLF 1
`define SFRPS_ST_LOCK 7
`define SFRPS_ST_WMASK 8'hbc
`define SFRPS_ST_RESET 8'h00
`define SFRPS_ERASED 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFRPS_CLK_NS 10
`define SFRPS_TW_NS 15000000
`define SFRPS_TPP_NS 3000000
`define SFRPS_TW_CYC (`SFRPS_TW_NS / `SFRPS_CLK_NS)
`define SFRPS_TPP_CYC (`SFRPS_TPP_NS / `SFRPS_CLK_NS)

`endif

// ---- pkg/sfrps_pkg.sv ----
// Types for the serial flash command sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sfrps_pkg;

   typedef enum logic [2:0] {
      SFRPS_IDLE,
      SFRPS_WRSR,
      SFRPS_DUMMY,
      SFRPS_RDATA,
      SFRPS_PROG,
      SFRPS_SINK
   } sfrps_phase_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } sfrps_link_in_t;

   typedef struct packed {
      logic so;
      logic io_o;
      logic io_oe;
   } sfrps_link_out_t;

endpackage

// ---- core/sfrps_timer.sv ----
// Self-timed cycle counter for program and status-write cycles.
// Assumes start pulses arrive only while idle.
`timescale 1ns/100ps
module sfrps_timer
   import sfrps_pkg::*;
#(
   parameter int TW_CYC = 1500000,
   parameter int TPP_CYC = 300000
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic start_sw,
   input wire logic start_pp,
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic busy;
      logic done;
   } sfrps_tmr_t;

   sfrps_tmr_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (s_r.busy) begin
         if (s_r.cnt <= 32'h1) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.cnt = 32'h0;
         end else begin
            s_nxt.cnt = s_r.cnt - 32'h1;
         end
      end else if (start_sw) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt = 32'(TW_CYC);
      end else if (start_pp) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt = 32'(TPP_CYC);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign done = s_r.done;
endmodule

// ---- core/sfrps_core.sv ----
// Serial flash command sequencer: status, reads, page program.
// Assumes link pins are synchronous to sys_clk and that sys_clk
// runs well above the link clock; edges are found by sampling.
`include "sfrps_cfg.svh"
`timescale 1ns/100ps

// What this block does
// - Status read shifts status MSB first
// - Status read answered even while busy
// - Status byte repeats until select rises
// - Status write needs write latch set
// - Status write touches bits 7,5,4,3,2 only
// - Status write needs exact byte end
// - Status write runs timed busy cycle
// - Lock bit plus guard pin block status writes
// - Protect bits select protected array region
// - Normal read: opcode, address, then data
// - Read address increments, streams whole array
// - Normal read ignored while busy
// - Fast read ignores eight dummy clocks
// - Dual read drives both lines
// - Page program needs latch and data
// - Program address wraps within page
// - Partial program leaves other bytes alone
// - Program needs select rise on byte end
// - Program runs timed busy cycle
// - Program into protected page refused
// - While busy only status read served
// - Write enable sets write latch
// - Writes end only on byte boundary
module sfrps_core
   import sfrps_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int TW_CYC = `SFRPS_TW_CYC,
   parameter int TPP_CYC = `SFRPS_TPP_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire sfrps_link_in_t link_in,
   input wire logic serial_in_bidir_line_i,
   input wire logic write_guard_n,
   output sfrps_link_out_t link_out,
   output logic [7:0] status_q
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int BLK_W = ADDR_W - 3;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      sfrps_phase_t ph;
      logic [7:0] op;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [1:0] abytes;
      logic [23:0] addr;
      logic [7:0] tx;
      logic [2:0] txcnt;
      logic dual;
      logic first;
      logic [7:0] pcnt;
      logic [7:0] pbase;
      logic [8:0] nbytes;
      logic [7:0] st;
      logic [7:0] wrsr_val;
      logic sclk_d;
      logic cs_d;
      logic so;
      logic io_o;
      logic io_oe;
      logic sw_go;
      logic pp_go;
      logic sw_run;
      logic [23:0] pp_addr;
      logic wr_buf;
      logic [7:0] wr_data;
      logic [7:0] wr_idx;
   } sfrps_core_t;

   sfrps_core_t s_r, s_nxt;

   logic [7:0] mem [DEPTH];
   logic [7:0] page_buf [256];
   logic [255:0] page_vld;
   logic [8:0] cp_idx;
   logic busy;
   logic cyc_done;
   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;
   logic [7:0] rd_byte;

   // Protected test over the block-sized slices of the small array
   function automatic logic is_protected(input logic [7:0] st, input logic [23:0] a);
      logic [2:0] rng;
      logic [BLK_W-1:0] blk;
      logic [3:0] n;
      rng = st[4:2];
      blk = a[ADDR_W-1:ADDR_W-BLK_W];
      n = 4'd0;
      if (rng == 3'h0) begin
         return 1'b0;
      end
      if (rng == 3'h7) begin
         return 1'b1;
      end
      n = 4'(7 - rng);
      if (st[5]) begin
         return (blk >> BLK_W'(n)) == '0;
      end
      return (blk >> BLK_W'(n)) == BLK_W'((1 << (BLK_W - n)) - 1);
   endfunction

   sfrps_timer #(
      .TW_CYC(TW_CYC),
      .TPP_CYC(TPP_CYC)
   ) u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .start_sw(s_r.sw_go),
      .start_pp(s_r.pp_go),
      .busy(busy),
      .done(cyc_done)
   );

   assign rise = link_in.sclk & ~s_r.sclk_d;
   assign fall = ~link_in.sclk & s_r.sclk_d;
   assign cs_rise = link_in.cs_n & ~s_r.cs_d;
   assign cs_fall = ~link_in.cs_n & s_r.cs_d;
   assign rd_byte = mem[s_r.addr[ADDR_W-1:0]];

   // ----------------------------------------
   // Command decode and shifting
   // ----------------------------------------
   always_comb begin
      logic [7:0] b;
      logic [7:0] stv;
      b = 8'h00;
      stv = 8'h00;
      s_nxt = s_r;
      s_nxt.sclk_d = link_in.sclk;
      s_nxt.cs_d = link_in.cs_n;
      s_nxt.sw_go = 1'b0;
      s_nxt.pp_go = 1'b0;
      s_nxt.wr_buf = 1'b0;
      s_nxt.st[`SFRPS_ST_BUSY] = busy | s_r.sw_go | s_r.pp_go;
      if (cyc_done) begin
         s_nxt.st[`SFRPS_ST_WLF] = 1'b0;
         // Polling during the cycle replaces the opcode, so a flag marks a status write
         if (s_r.sw_run) begin
            s_nxt.sw_run = 1'b0;
            stv = s_r.st;
            stv = (stv & ~`SFRPS_ST_WMASK) | (s_r.wrsr_val & `SFRPS_ST_WMASK);
            s_nxt.st[7:2] = stv[7:2];
         end
      end
      if (link_in.cs_n) begin
         s_nxt.io_oe = 1'b0;
         s_nxt.so = 1'b0;
         s_nxt.io_o = 1'b0;
         if (cs_rise && s_r.bits == 4'd0 && !s_nxt.st[`SFRPS_ST_BUSY]) begin
            if (s_r.ph == SFRPS_WRSR && s_r.nbytes == 9'd1) begin
               s_nxt.sw_go = 1'b1;
               s_nxt.sw_run = 1'b1;
            end else if (s_r.ph == SFRPS_PROG && s_r.nbytes != 9'd0 &&
                  !is_protected(s_r.st, s_r.pp_addr)) begin
               s_nxt.pp_go = 1'b1;
            end else if (s_r.ph == SFRPS_IDLE && s_r.abytes == 2'd0 && s_r.first == 1'b0) begin
               if (s_r.op == `SFRPS_OP_WREN) begin
                  s_nxt.st[`SFRPS_ST_WLF] = 1'b1;
               end else if (s_r.op == `SFRPS_OP_WRDI) begin
                  s_nxt.st[`SFRPS_ST_WLF] = 1'b0;
               end
            end
         end
         s_nxt.ph = SFRPS_IDLE;
         s_nxt.bits = 4'd0;
         s_nxt.first = 1'b1;
         s_nxt.abytes = 2'd0;
      end else begin
         if (cs_fall) begin
            s_nxt.first = 1'b1;
            s_nxt.nbytes = 9'd0;
         end
         if (rise) begin
            b = {s_r.sh[6:0], link_in.din};
            s_nxt.sh = b;
            s_nxt.bits = (s_r.bits == 4'd7) ? 4'd0 : s_r.bits + 4'd1;
            if (s_r.bits == 4'd7) begin
               if (s_r.first) begin
                  s_nxt.first = 1'b0;
                  s_nxt.op = b;
                  s_nxt.ph = SFRPS_SINK;
                  s_nxt.abytes = 2'd0;
                  s_nxt.txcnt = 3'd0;
                  s_nxt.dual = 1'b0;
                  if (b == `SFRPS_OP_RDSR) begin
                     s_nxt.ph = SFRPS_RDATA;
                     s_nxt.tx = s_nxt.st;
                  end else if (s_nxt.st[`SFRPS_ST_BUSY]) begin
                     s_nxt.ph = SFRPS_SINK;
                  end else if (b == `SFRPS_OP_WRSR) begin
                     if (s_r.st[`SFRPS_ST_WLF] &&
                           !(s_r.st[`SFRPS_ST_LOCK] && !write_guard_n)) begin
                        s_nxt.ph = SFRPS_WRSR;
                     end
                  end else if (b == `SFRPS_OP_PP) begin
                     if (s_r.st[`SFRPS_ST_WLF]) begin
                        s_nxt.ph = SFRPS_IDLE;
                        s_nxt.abytes = 2'd3;
                     end
                  end else if (b == `SFRPS_OP_READ || b == `SFRPS_OP_FAST || b == `SFRPS_OP_DUAL) begin
                     s_nxt.ph = SFRPS_IDLE;
                     s_nxt.abytes = 2'd3;
                  end else if (b == `SFRPS_OP_WREN || b == `SFRPS_OP_WRDI) begin
                     s_nxt.ph = SFRPS_IDLE;
                  end
               end else if (s_r.abytes != 2'd0) begin
                  s_nxt.addr = {s_r.addr[15:0], b};
                  s_nxt.abytes = s_r.abytes - 2'd1;
                  if (s_r.abytes == 2'd1) begin
                     s_nxt.dual = (s_r.op == `SFRPS_OP_DUAL);
                     if (s_r.op == `SFRPS_OP_PP) begin
                        s_nxt.ph = SFRPS_PROG;
                        s_nxt.pp_addr = {s_r.addr[15:0], b};
                        s_nxt.pbase = b;
                        s_nxt.pcnt = 8'h00;
                     end else if (s_r.op == `SFRPS_OP_READ) begin
                        s_nxt.ph = SFRPS_RDATA;
                        s_nxt.tx = mem[ADDR_W'({s_r.addr[15:0], b})];
                     end else begin
                        s_nxt.ph = SFRPS_DUMMY;
                     end
                  end
               end else if (s_r.ph == SFRPS_DUMMY) begin
                  s_nxt.ph = SFRPS_RDATA;
                  s_nxt.tx = rd_byte;
               end else if (s_r.ph == SFRPS_WRSR) begin
                  s_nxt.wrsr_val = b;
                  s_nxt.nbytes = s_r.nbytes + 9'd1;
               end else if (s_r.ph == SFRPS_PROG) begin
                  s_nxt.wr_buf = 1'b1;
                  s_nxt.wr_data = b;
                  s_nxt.wr_idx = s_r.pbase + s_r.pcnt;
                  s_nxt.pcnt = s_r.pcnt + 8'h01;
                  s_nxt.nbytes = (s_r.nbytes == 9'd256) ? 9'd256 : s_r.nbytes + 9'd1;
               end
            end
         end
         // Read data shifts out on falling edges
         if (fall && s_r.ph == SFRPS_RDATA) begin
            if (s_r.dual) begin
               s_nxt.so = s_r.tx[7];
               s_nxt.io_o = s_r.tx[6];
               s_nxt.io_oe = 1'b1;
               s_nxt.tx = {s_r.tx[5:0], 2'b00};
               s_nxt.txcnt = s_r.txcnt + 3'd1;
               if (s_r.txcnt[1:0] == 2'd3) begin
                  s_nxt.addr = s_r.addr + 24'h1;
                  s_nxt.tx = mem[ADDR_W'(s_r.addr + 24'h1)];
                  s_nxt.txcnt = 3'd0;
               end
            end else begin
               s_nxt.so = s_r.tx[7];
               s_nxt.tx = {s_r.tx[6:0], 1'b0};
               s_nxt.txcnt = s_r.txcnt + 3'd1;
               if (s_r.txcnt == 3'd7) begin
                  if (s_r.op == `SFRPS_OP_RDSR) begin
                     s_nxt.tx = s_nxt.st;
                  end else begin
                     s_nxt.addr = s_r.addr + 24'h1;
                     s_nxt.tx = mem[ADDR_W'(s_r.addr + 24'h1)];
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.ph <= SFRPS_IDLE;
         s_r.sclk_d <= 1'b0;
         s_r.cs_d <= 1'b1;
         s_r.first <= 1'b1;
         s_r.st <= `SFRPS_ST_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Page buffer and array commit
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         page_vld <= '0;
         cp_idx <= 9'd0;
         // Array starts erased so programming has bits to clear
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= `SFRPS_ERASED;
         end
      end else begin
         // Polling must not wipe the buffer; the commit ends well inside the program cycle
         if (cs_fall && !s_r.st[`SFRPS_ST_BUSY]) begin
            page_vld <= '0;
         end
         if (s_r.wr_buf) begin
            page_buf[s_r.wr_idx] <= s_r.wr_data;
            page_vld[s_r.wr_idx] <= 1'b1;
         end
         if (s_r.pp_go) begin
            cp_idx <= 9'h100;
         end else if (cp_idx != 9'd0) begin
            cp_idx <= cp_idx - 9'd1;
            if (page_vld[cp_idx[7:0] - 8'h01]) begin
               // Programming clears bits only; untouched bytes stay as they were
               mem[ADDR_W'({s_r.pp_addr[23:8], 8'(cp_idx[7:0] - 8'h01)})] <=
                  mem[ADDR_W'({s_r.pp_addr[23:8], 8'(cp_idx[7:0] - 8'h01)})] &
                  page_buf[cp_idx[7:0] - 8'h01];
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link_out.so = s_r.so;
   assign link_out.io_o = s_r.io_o;
   assign link_out.io_oe = s_r.io_oe;
   assign status_q = s_r.st;

endmodule

// ---- bench/sfrps_checker.sv ----
// Concurrent checks on the serial flash sequencer's ports.
// Assumes it is bound into sfrps_core and sees only its ports.
`timescale 1ns/100ps
module sfrps_checker
   import sfrps_pkg::*;
#(
   parameter int TW_CYC = 20,
   parameter int TPP_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire sfrps_link_in_t link_in,
   input wire logic serial_in_bidir_line_i,
   input wire logic write_guard_n,
   input wire sfrps_link_out_t link_out,
   input wire logic [7:0] status_q
);
   localparam int LO = (TW_CYC < TPP_CYC ? TW_CYC : TPP_CYC) - 2;
   localparam int HI = (TW_CYC > TPP_CYC ? TW_CYC : TPP_CYC) + 2;
   int busy_len_r;

   // Length of the current self-timed cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !status_q[0]) begin
         busy_len_r <= 0;
      end else begin
         busy_len_r <= busy_len_r + 1;
      end
   end

   AST_IO_OE_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
      link_in.cs_n && $past(link_in.cs_n, 4) |-> !link_out.io_oe)
      else $error("bidir line driven while deselected");
   AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !status_q[6])
      else $error("reserved status bit set");
   AST_PROT_AT_END: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(status_q[7:2]) |-> $past(status_q[0], 1) || $past(status_q[0], 2))
      else $error("protect bits changed outside a write cycle end");
   AST_LATCH_CLEAR: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(status_q[0]) |-> ##[0:1] !status_q[1])
      else $error("write latch not cleared at cycle end");
   AST_BUSY_START: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(status_q[0]) |-> link_in.cs_n && status_q[1])
      else $error("busy started without latch or inside a frame");
   AST_BUSY_LEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(status_q[0]) |-> busy_len_r >= LO && busy_len_r <= HI)
      else $error("self-timed cycle length wrong");
   AST_BUSY_CAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      status_q[0] |-> busy_len_r <= HI)
      else $error("self-timed cycle overran");
   AST_SO_ON_LOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !link_in.cs_n && $changed(link_out.so) |-> !link_in.sclk)
      else $error("serial out changed while link clock high");
endmodule

bind sfrps_core sfrps_checker #(.TW_CYC(TW_CYC), .TPP_CYC(TPP_CYC)) u_chk (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .link_in(link_in),
   .serial_in_bidir_line_i(serial_in_bidir_line_i),
   .write_guard_n(write_guard_n),
   .link_out(link_out),
   .status_q(status_q)
);

// ---- bench/sfrps_host.sv ----
// Host link master model driving select, link clock and data line.
// Assumes tasks are called from a process synchronous to sys_clk.
`timescale 1ns/100ps
module sfrps_host
   import sfrps_pkg::*;
(
   input wire logic sys_clk,
   input wire sfrps_link_out_t link_out,
   output sfrps_link_in_t link_in
);
   localparam int HALF = 6;
   logic cs_n_r = 1'b1;
   logic sclk_r = 1'b0;
   logic hd_r = 1'b1;
   logic hoe_r = 1'b1;

   // Released line shows the inverse of the last driven value
   assign link_in = '{cs_n: cs_n_r, sclk: sclk_r,
      din: link_out.io_oe ? link_out.io_o : (hoe_r ? hd_r : ~hd_r)};

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic start();
      @(posedge sys_clk);
      cs_n_r <= 1'b0;
      wait_n(HALF);
   endtask

   // One link clock; both output lines captured before the rise
   task automatic tick(input logic d, output logic s, output logic i);
      sclk_r <= 1'b0;
      hd_r <= d;
      wait_n(HALF);
      s = link_out.so;
      i = link_out.io_o;
      sclk_r <= 1'b1;
      wait_n(HALF);
   endtask

   task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
      logic s, i;
      for (int k = 7; k >= 0; k--) begin
         tick(tx[k], s, i);
         rx[k] = s;
      end
   endtask

   task automatic dual_byte(output logic [7:0] rx);
      logic s, i;
      for (int k = 7; k > 0; k -= 2) begin
         tick(1'b0, s, i);
         rx[k] = s;
         rx[k-1] = i;
      end
   endtask

   task automatic release_line();
      hoe_r <= 1'b0;
      wait_n(1);
   endtask

   task automatic stop();
      sclk_r <= 1'b0;
      wait_n(HALF);
      cs_n_r <= 1'b1;
      hoe_r <= 1'b1;
      wait_n(4 * HALF);
   endtask
endmodule

// ---- bench/test_serial_flash_read_program_status.sv ----
// Self-checking bench for the serial flash command sequencer.
// Assumes sfrps_host as link master and the bound checker.
`timescale 1ns/100ps
module test_serial_flash_read_program_status
   import sfrps_pkg::*;
;
   localparam int CYC = 2000;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic write_guard_n = 1'b1;
   sfrps_link_in_t link_in;
   sfrps_link_out_t link_out;
   logic [7:0] status_q;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;

   always #5 sys_clk = ~sys_clk;

   sfrps_core #(.ADDR_W(12), .TW_CYC(CYC), .TPP_CYC(CYC)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link_in(link_in),
      .serial_in_bidir_line_i(link_in.din), .write_guard_n(write_guard_n),
      .link_out(link_out), .status_q(status_q));
   sfrps_host host (.sys_clk(sys_clk), .link_out(link_out), .link_in(link_in));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic op(input logic [7:0] code, input logic [23:0] a, input int nadr);
      logic [7:0] rx;
      host.start();
      host.byte_x(code, rx);
      for (int k = 0; k < nadr; k++) host.byte_x(a[23-8*k -: 8], rx);
   endtask

   task automatic simple(input logic [7:0] code);
      op(code, 24'h0, 0);
      host.stop();
   endtask

   task automatic rdsr(output logic [7:0] st);
      op(8'h05, 24'h0, 0);
      host.byte_x(8'h00, st);
      host.stop();
   endtask

   task automatic wait_idle();
      logic [7:0] st;
      int n = 0;
      do begin
         rdsr(st);
         n++;
      end while (st[0] !== 1'b0 && n < 50);
      check("busy end", 8'h00, {7'h0, st[0]});
   endtask

   task automatic wrsr(input logic [7:0] v, input int nbits);
      logic s, i;
      op(8'h01, 24'h0, 0);
      for (int k = 7; k > 7 - nbits; k--) host.tick(v[k], s, i);
      host.stop();
   endtask

   task automatic pp(input logic [23:0] a, input int n, input logic [7:0] base, input int cut);
      logic [7:0] rx;
      logic s, i;
      op(8'h02, a, 3);
      for (int k = 0; k < n; k++) host.byte_x(base + 8'(k), rx);
      for (int k = 0; k < cut; k++) host.tick(1'b1, s, i);
      host.stop();
   endtask

   task automatic rd(input logic [7:0] code, input logic [23:0] a, input int n, input logic [7:0] base);
      logic [7:0] rx;
      op(code, a, 3);
      if (code != 8'h03) host.byte_x(8'h5a, rx);
      if (code == 8'h3b) host.release_line();
      for (int k = 0; k < n; k++) begin
         if (code == 8'h3b) host.dual_byte(rx);
         else host.byte_x(8'h00, rx);
         check("read data", base + 8'(k), rx);
      end
      host.stop();
      if (code == 8'h3b) check("bidir released", 8'h00, {7'h0, link_out.io_oe});
   endtask

   task automatic t_status();
      logic [7:0] st, b;
      check("reset status", 8'h00, status_q);
      wrsr(8'hff, 8);
      rdsr(st);
      check("write without latch", 8'h00, st);
      simple(8'h06);
      rdsr(st);
      check("latch set", 8'h02, st);
      wrsr(8'hff, 5);
      rdsr(st);
      check("cut status write", 8'h02, st);
      write_guard_n <= 1'b0;
      wrsr(8'hff, 8);
      rdsr(st);
      check("busy in write", 8'h03, st);
      simple(8'h06);
      wait_idle();
      rdsr(st);
      check("written bits", 8'hbc, st);
      simple(8'h06);
      wrsr(8'h00, 8);
      rdsr(st);
      check("guarded write", 8'hbc, st & 8'hfd);
      write_guard_n <= 1'b1;
      simple(8'h06);
      wrsr(8'h9c, 8);
      wait_idle();
      op(8'h05, 24'h0, 0);
      host.byte_x(8'h00, st);
      host.byte_x(8'h00, b);
      host.stop();
      check("status msb first", 8'h9c, st);
      check("status repeat", 8'h9c, b);
      simple(8'h06);
      pp(24'h000300, 1, 8'h11, 0);
      rdsr(st);
      check("protected program", 8'h00, {7'h0, st[0]});
      simple(8'h06);
      wrsr(8'h00, 8);
      wait_idle();
      rdsr(st);
      check("status cleared", 8'h00, st);
      $display("test status done");
   endtask

   task automatic t_prog();
      logic [7:0] st;
      simple(8'h06);
      pp(24'h0000f8, 10, 8'ha0, 0);
      op(8'h03, 24'h0000f8, 3);
      host.byte_x(8'h00, st);
      host.stop();
      rdsr(st);
      check("busy in program", 8'h03, st);
      wait_idle();
      rdsr(st);
      check("latch after program", 8'h00, st);
      rd(8'h03, 24'h0000f8, 8, 8'ha0);
      rd(8'h03, 24'h000000, 2, 8'ha8);
      rd(8'h0b, 24'h0000f8, 4, 8'ha0);
      rd(8'h3b, 24'h0000fc, 4, 8'ha4);
      simple(8'h06);
      pp(24'h000200, 2, 8'h30, 0);
      wait_idle();
      simple(8'h06);
      pp(24'h000202, 2, 8'h32, 0);
      wait_idle();
      rd(8'h03, 24'h000200, 4, 8'h30);
      simple(8'h06);
      pp(24'h000200, 1, 8'h00, 3);
      rdsr(st);
      check("cut program", 8'h02, st);
      rd(8'h03, 24'h000200, 2, 8'h30);
      $display("test program done");
   endtask

   task automatic give_verdict();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_status();
      t_prog();
      give_verdict();
   end
endmodule
